// ==== hdl/ddr_memory_io_datapath.v ====
// double data rate memory pin datapath: read capture, read fifo, write output and clock generation
`include "ddr_io_defs.vh"

module ddr_memory_io_datapath #(
    parameter DQ_WIDTH = `DQ_WIDTH_DEFAULT,
    parameter CMD_WIDTH = `CMD_WIDTH_DEFAULT,
    parameter ADDR_WIDTH = `ADDR_WIDTH_DEFAULT,
    parameter MEM_CLK_DIV = `MEM_CLK_DIV,
    parameter FIFO_ABITS = `FIFO_ADDR_BITS
) (
    input wire sys_clk,
    input wire srst,
    // core write side
    input wire wr_valid,
    input wire [DQ_WIDTH-1:0] wr_data_h,
    input wire [DQ_WIDTH-1:0] wr_data_l,
    input wire wr_mask_h,
    input wire wr_mask_l,
    input wire [CMD_WIDTH-1:0] cmd_in,
    input wire [ADDR_WIDTH-1:0] addr_in,
    // core read side
    input wire rd_capture_en,
    input wire [$clog2(MEM_CLK_DIV)-1:0] cap_phase,
    input wire rd_ready,
    output reg rd_valid_reg,
    output reg [DQ_WIDTH-1:0] rd_data_h_reg,
    output reg [DQ_WIDTH-1:0] rd_data_l_reg,
    output reg rd_overrun_reg,
    output reg period_start_reg,
    // memory pins
    input wire [DQ_WIDTH-1:0] dq_in,
    output reg [DQ_WIDTH-1:0] dq_out_reg,
    output reg [DQ_WIDTH-1:0] dq_oe_n_reg,
    output reg dm_out_reg,
    output reg dqs_out_reg,
    output reg dqs_oe_n_reg,
    output reg ck_out_reg,
    output reg ck_n_out_reg,
    output reg [CMD_WIDTH-1:0] cmd_out_reg,
    output reg [ADDR_WIDTH-1:0] addr_out_reg
);
    // divider must be a power of two so phase arithmetic wraps for free
    localparam PW = $clog2(MEM_CLK_DIV);
    // phase points worked out as integers, then cut to the counter width on purpose
    localparam integer PH_LAST_I = MEM_CLK_DIV - 1;
    localparam integer PH_HALF_I = MEM_CLK_DIV / `MEM_CLK_HALF_DEN;
    localparam integer PH_QTR_I = MEM_CLK_DIV * `MEM_CLK_QUARTER_NUM / `MEM_CLK_QUARTER_DEN;
    localparam integer PH_WR_FALL_I = PH_QTR_I + PH_HALF_I;
    localparam integer PH_ZERO_I = `PHASE_ZERO;
    localparam integer CAP_RST_I = `CAP_PHASE_RESET;
    localparam integer FIFO_FULL_I = 1 << FIFO_ABITS;
    localparam integer ONE_I = 1;
    localparam [PW-1:0] PH_LAST = PH_LAST_I[PW-1:0];
    localparam [PW-1:0] PH_HALF = PH_HALF_I[PW-1:0];
    localparam [PW-1:0] PH_QTR = PH_QTR_I[PW-1:0];
    localparam [PW-1:0] PH_WR_FALL = PH_WR_FALL_I[PW-1:0];
    localparam [PW-1:0] PH_ZERO = PH_ZERO_I[PW-1:0];
    localparam [PW-1:0] CAP_RST = CAP_RST_I[PW-1:0];
    localparam [PW-1:0] PH_ONE = ONE_I[PW-1:0];
    localparam PAIR_W = 2 * DQ_WIDTH;
    localparam [FIFO_ABITS:0] FIFO_FULL = FIFO_FULL_I[FIFO_ABITS:0];
    localparam [FIFO_ABITS:0] CNT_ONE = ONE_I[FIFO_ABITS:0];
    localparam [FIFO_ABITS-1:0] PTR_ONE = ONE_I[FIFO_ABITS-1:0];

    // =========================================================
    // phase generator
    // =========================================================
    reg [PW-1:0] ph_reg;
    reg [PW-1:0] cap_phase_reg;
    wire sys_rise = (ph_reg == PH_ZERO);
    wire sys_fall = (ph_reg == PH_HALF);
    wire wr_rise = (ph_reg == PH_QTR);
    wire wr_fall = (ph_reg == PH_WR_FALL);
    wire cap_rise = (ph_reg == cap_phase_reg);
    wire [PW-1:0] cap_fall_ph = cap_phase_reg + PH_HALF;
    wire cap_fall = (ph_reg == cap_fall_ph);

    always @(posedge sys_clk) begin
        if (srst) begin
            ph_reg <= PH_ZERO;
            cap_phase_reg <= CAP_RST;
            period_start_reg <= 1'b0;
        end else begin
            ph_reg <= (ph_reg == PH_LAST) ? PH_ZERO : ph_reg + PH_ONE;
            // phase only taken at period start so capture edges never double up
            if (ph_reg == PH_LAST) begin
                cap_phase_reg <= cap_phase;
            end
            period_start_reg <= (ph_reg == PH_LAST);
        end
    end

    // =========================================================
    // memory clock pair and command launch
    // =========================================================
    always @(posedge sys_clk) begin
        if (srst) begin
            ck_out_reg <= `PIN_IDLE_LEVEL;
            ck_n_out_reg <= ~`PIN_IDLE_LEVEL;
            cmd_out_reg <= {CMD_WIDTH{1'b0}};
            addr_out_reg <= {ADDR_WIDTH{1'b0}};
        end else begin
            if (sys_rise) begin
                ck_out_reg <= 1'b1;
                ck_n_out_reg <= 1'b0;
                cmd_out_reg <= cmd_in;
                addr_out_reg <= addr_in;
            end else if (sys_fall) begin
                ck_out_reg <= 1'b0;
                ck_n_out_reg <= 1'b1;
            end
        end
    end

    // =========================================================
    // write path
    // =========================================================
    reg [DQ_WIDTH-1:0] out_a_reg;
    reg [DQ_WIDTH-1:0] out_b_reg;
    reg mask_a_reg;
    reg mask_b_reg;
    reg oe_a_reg;
    reg oe_b_reg;
    reg dqs_oe_a_reg;
    reg dqs_oe_b_reg;
    reg wr_active_reg;

    // both streams enter on the same system rise
    always @(posedge sys_clk) begin
        if (srst) begin
            out_a_reg <= {DQ_WIDTH{1'b0}};
            out_b_reg <= {DQ_WIDTH{1'b0}};
            mask_a_reg <= 1'b0;
            mask_b_reg <= 1'b0;
            wr_active_reg <= 1'b0;
        end else if (sys_rise) begin
            out_a_reg <= wr_data_l;
            out_b_reg <= wr_data_h;
            mask_a_reg <= wr_mask_l;
            mask_b_reg <= wr_mask_h;
            wr_active_reg <= wr_valid;
        end
    end

    // per-pin double_rate_io_block, data and enable side by side
    genvar g;
    generate
        for (g = 0; g < DQ_WIDTH; g = g + 1) begin : g_dq_out
            always @(posedge sys_clk) begin
                if (srst) begin
                    dq_out_reg[g] <= `PIN_IDLE_LEVEL;
                    dq_oe_n_reg[g] <= `OE_N_OFF;
                end else if (wr_rise) begin
                    dq_out_reg[g] <= out_b_reg[g];
                    dq_oe_n_reg[g] <= ~oe_b_reg;
                end else if (wr_fall) begin
                    dq_out_reg[g] <= out_a_reg[g];
                    dq_oe_n_reg[g] <= ~oe_a_reg;
                end
            end
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (srst) begin
            oe_a_reg <= 1'b0;
            oe_b_reg <= 1'b0;
            dm_out_reg <= `PIN_IDLE_LEVEL;
        end else begin
            if (sys_rise) begin
                oe_a_reg <= wr_valid;
                oe_b_reg <= wr_valid;
            end
            if (wr_rise) begin
                dm_out_reg <= mask_b_reg;
            end else if (wr_fall) begin
                dm_out_reg <= mask_a_reg;
            end
        end
    end

    // strobe: first enable follows the burst, second one lags half a period
    always @(posedge sys_clk) begin
        if (srst) begin
            dqs_oe_a_reg <= 1'b0;
            dqs_oe_b_reg <= 1'b0;
            dqs_out_reg <= `PIN_IDLE_LEVEL;
            dqs_oe_n_reg <= `OE_N_OFF;
        end else begin
            if (sys_rise) begin
                dqs_oe_a_reg <= wr_valid;
                dqs_oe_n_reg <= ~(wr_valid & dqs_oe_b_reg);
                dqs_out_reg <= wr_active_reg;
            end else if (sys_fall) begin
                dqs_oe_b_reg <= dqs_oe_a_reg;
                dqs_oe_n_reg <= ~dqs_oe_a_reg;
                dqs_out_reg <= 1'b0;
            end
        end
    end

    // =========================================================
    // read capture: returned strobe is never looked at
    // =========================================================
    reg [DQ_WIDTH-1:0] dq_s1_reg;
    reg [DQ_WIDTH-1:0] dq_s2_reg;
    reg [DQ_WIDTH-1:0] dq_s3_reg;
    reg [DQ_WIDTH-1:0] dq_clean_reg;
    reg [DQ_WIDTH-1:0] cap_a_reg;
    reg [DQ_WIDTH-1:0] cap_b_reg;
    reg [DQ_WIDTH-1:0] cap_c_reg;
    reg pair_ready_reg;

    generate
        for (g = 0; g < DQ_WIDTH; g = g + 1) begin : g_dq_in
            always @(posedge sys_clk) begin
                if (srst) begin
                    dq_s1_reg[g] <= 1'b0;
                    dq_s2_reg[g] <= 1'b0;
                    dq_s3_reg[g] <= 1'b0;
                    dq_clean_reg[g] <= 1'b0;
                    cap_a_reg[g] <= 1'b0;
                    cap_b_reg[g] <= 1'b0;
                    cap_c_reg[g] <= 1'b0;
                end else begin
                    dq_s1_reg[g] <= dq_in[g];
                    dq_s2_reg[g] <= dq_s1_reg[g];
                    dq_s3_reg[g] <= dq_s2_reg[g];
                    if (dq_s2_reg[g] == dq_s3_reg[g]) begin
                        dq_clean_reg[g] <= dq_s3_reg[g];
                    end
                    if (cap_rise) begin
                        cap_a_reg[g] <= dq_clean_reg[g];
                    end
                    if (cap_fall) begin
                        cap_b_reg[g] <= dq_clean_reg[g];
                        cap_c_reg[g] <= cap_a_reg[g];
                    end
                end
            end
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (srst) begin
            pair_ready_reg <= 1'b0;
        end else begin
            pair_ready_reg <= cap_fall & rd_capture_en;
        end
    end

    // =========================================================
    // read fifo into the system clock domain
    // =========================================================
    reg [FIFO_ABITS-1:0] wptr_reg;
    reg [FIFO_ABITS-1:0] rptr_reg;
    reg [FIFO_ABITS:0] count_reg;
    reg rd_pend_reg;
    wire [PAIR_W-1:0] fifo_q;
    wire fifo_full = (count_reg == FIFO_FULL);
    wire push = pair_ready_reg & ~fifo_full;
    wire pop = (count_reg != {(FIFO_ABITS+1){1'b0}}) & ~rd_pend_reg & (~rd_valid_reg | rd_ready);

    read_fifo_mem #(
        .WIDTH(PAIR_W),
        .ABITS(FIFO_ABITS)
    ) u_read_fifo_mem (
        .sys_clk(sys_clk),
        .wr_en(push),
        .wr_addr(wptr_reg),
        .wr_data({cap_c_reg, cap_b_reg}),
        .rd_en(pop),
        .rd_addr(rptr_reg),
        .rd_data(fifo_q)
    );

    always @(posedge sys_clk) begin
        if (srst) begin
            wptr_reg <= {FIFO_ABITS{1'b0}};
            rptr_reg <= {FIFO_ABITS{1'b0}};
            count_reg <= {(FIFO_ABITS+1){1'b0}};
            rd_pend_reg <= 1'b0;
            rd_valid_reg <= 1'b0;
            rd_data_h_reg <= {DQ_WIDTH{1'b0}};
            rd_data_l_reg <= {DQ_WIDTH{1'b0}};
            rd_overrun_reg <= 1'b0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + PTR_ONE;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + PTR_ONE;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + CNT_ONE;
            end else if (pop & ~push) begin
                count_reg <= count_reg - CNT_ONE;
            end
            // a full fifo drops the pair; flag stays until reset
            if (pair_ready_reg & fifo_full) begin
                rd_overrun_reg <= 1'b1;
            end
            rd_pend_reg <= pop;
            if (rd_pend_reg) begin
                rd_valid_reg <= 1'b1;
                rd_data_h_reg <= fifo_q[PAIR_W-1:DQ_WIDTH];
                rd_data_l_reg <= fifo_q[DQ_WIDTH-1:0];
            end else if (rd_ready) begin
                rd_valid_reg <= 1'b0;
            end
        end
    end
endmodule // ddr_memory_io_datapath

// ==== common/ddr_io_defs.vh ====
// timing, sizing and reset constants for the memory i/o datapath
// How it works
// - each data pin's read path uses three core_logic_flop registers next to it
// - first capture register samples the data pin on capture clock rising edge
// - second capture register samples the data pin on capture clock falling edge
// - third register realigns so both captured words are presented together
// - captured high/low pair passes through a fifo into the system clock domain
// - reads use the generated capture clock; returned strobe ignored, no postamble gate
// - double_rate_io_block exists in both data output and output enable paths
// - low and high write streams load their output registers on one edge
// - low register retimed on falling edge, high register on rising edge
// - retimed pair selected by the same clock, two bits per period
// - output enable path mirrors the data path onto the tristate control
// - second active-low enable keeps strobe high-z half a cycle longer on writes
// - phase generator yields system, write and capture clocks from the core clock
// - write strobe, commands and addresses launch from the system clock
// - write data launches from a write clock lagging a quarter period
// - write mask launches from the same lagging write clock as data
// - memory clock pair made by double rate registers like the strobe
`ifndef DDR_IO_DEFS_VH
`define DDR_IO_DEFS_VH

`define CORE_CLK_PERIOD_NS 40
`define MEM_CLK_DIV 8
`define MEM_CLK_QUARTER_NUM 1
`define MEM_CLK_QUARTER_DEN 4
`define MEM_CLK_HALF_DEN 2
`define DQ_WIDTH_DEFAULT 8
`define CMD_WIDTH_DEFAULT 4
`define ADDR_WIDTH_DEFAULT 13
`define FIFO_ADDR_BITS 2
`define PHASE_ZERO 0
`define CAP_PHASE_RESET 0
`define PIN_IDLE_LEVEL 1'b0
`define OE_N_OFF 1'b1

`endif

// ==== hdl/read_fifo_mem.v ====
// small dual-port memory holding captured read pairs, registered read data
module read_fifo_mem #(
    parameter WIDTH = 16,
    parameter ABITS = 2
) (
    input wire sys_clk,
    input wire wr_en,
    input wire [ABITS-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire rd_en,
    input wire [ABITS-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:(1<<ABITS)-1];

    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // read_fifo_mem

// ==== tb/ddr_memory_io_datapath_assertions.sv ====
// assertion checker for the memory pin datapath
module ddr_io_checker #(
    parameter DQ_WIDTH = 8,
    parameter CMD_WIDTH = 4
) (
    input wire sys_clk,
    input wire srst,
    input wire wr_valid,
    input wire [DQ_WIDTH-1:0] wr_data_h,
    input wire [DQ_WIDTH-1:0] wr_data_l,
    input wire wr_mask_h,
    input wire wr_mask_l,
    input wire [CMD_WIDTH-1:0] cmd_in,
    input wire rd_ready,
    input wire rd_valid_reg,
    input wire [DQ_WIDTH-1:0] rd_data_h_reg,
    input wire [DQ_WIDTH-1:0] rd_data_l_reg,
    input wire rd_overrun_reg,
    input wire period_start_reg,
    input wire [DQ_WIDTH-1:0] dq_out_reg,
    input wire [DQ_WIDTH-1:0] dq_oe_n_reg,
    input wire dm_out_reg,
    input wire dqs_out_reg,
    input wire dqs_oe_n_reg,
    input wire ck_out_reg,
    input wire [CMD_WIDTH-1:0] cmd_out_reg
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // ==========
    // pin timing, overrun flag and read hold
    a_period_pulse: assert property (period_start_reg |=> !period_start_reg [*7] ##1 period_start_reg)
        else $error("period pulse spacing wrong");
    a_clock_shape: assert property (period_start_reg |=> ck_out_reg [*4] ##1 !ck_out_reg [*4])
        else $error("memory clock shape wrong");
    a_cmd_launch: assert property (period_start_reg |=> cmd_out_reg == $past(cmd_in) ##1 $stable(cmd_out_reg) [*7])
        else $error("command not launched at period start");
    a_write_beats: assert property (period_start_reg && wr_valid |-> ##3
        (dq_out_reg == $past(wr_data_h, 3) && dm_out_reg == $past(wr_mask_h, 3) && dq_oe_n_reg == '0)
        ##4 (dq_out_reg == $past(wr_data_l, 7) && dm_out_reg == $past(wr_mask_l, 7)))
        else $error("write beats wrong");
    a_strobe_preamble: assert property (period_start_reg && wr_valid && dqs_oe_n_reg |->
        ##3 (dqs_oe_n_reg && !dq_oe_n_reg[0]) ##2 (!dqs_oe_n_reg && !dqs_out_reg))
        else $error("strobe preamble wrong");
    a_strobe_burst: assert property (period_start_reg && wr_valid && !dqs_oe_n_reg |=> dqs_out_reg && !dqs_oe_n_reg)
        else $error("strobe not driven high in burst");
    a_overrun_sticky: assert property (rd_overrun_reg |=> rd_overrun_reg)
        else $error("overrun flag cleared");
    a_read_hold: assert property (rd_valid_reg && !rd_ready |=>
        rd_valid_reg && $stable(rd_data_h_reg) && $stable(rd_data_l_reg))
        else $error("read pair not held");
endmodule // ddr_io_checker

bind ddr_memory_io_datapath ddr_io_checker #(.DQ_WIDTH(DQ_WIDTH), .CMD_WIDTH(CMD_WIDTH)) chk_u (
    .sys_clk, .srst, .wr_valid, .wr_data_h, .wr_data_l, .wr_mask_h, .wr_mask_l, .cmd_in, .rd_ready,
    .rd_valid_reg, .rd_data_h_reg, .rd_data_l_reg, .rd_overrun_reg, .period_start_reg, .dq_out_reg,
    .dq_oe_n_reg, .dm_out_reg, .dqs_out_reg, .dqs_oe_n_reg, .ck_out_reg, .cmd_out_reg);

// ==== tb/mem_device_model.sv ====
// memory device stand-in returning read words on memory clock edges
module mem_device_model (
    input wire logic ck,
    input wire logic rd_drive,
    input wire logic [7:0] word_h,
    input wire logic [7:0] word_l,
    output wire logic [7:0] dq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] bus_reg = 8'h5a;
    assign dq = bus_reg;
    // no read strobe returned, the capture side must not need one
    // released bus toggles so a stale word never matches by luck
    always @(posedge ck or negedge ck) begin
        if (rd_drive) begin
            bus_reg <= #3 ck ? word_h : word_l;
        end else begin
            bus_reg <= #3 ~bus_reg;
        end
    end
endmodule // mem_device_model

// ==== tb/ddr_memory_io_datapath_bench.sv ====
// self-checking bench for the memory pin datapath
module ddr_memory_io_datapath_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // signals
    logic sys_clk, srst, wr_valid, wr_mask_h, wr_mask_l, rd_capture_en, rd_ready, rd_drive, hold_ready, prev_v;
    logic [7:0] wr_data_h, wr_data_l, word_h, word_l;
    logic [3:0] cmd_in;
    logic [12:0] addr_in;
    logic [2:0] cap_phase;
    logic [31:0] seed;
    logic [31:0] rseed = 32'haa76;
    logic [15:0] exp_q[$];
    int bad_count, total_checks;
    wire rd_valid_reg, rd_overrun_reg, period_start_reg, dm_out_reg, dqs_out_reg, dqs_oe_n_reg, ck_out_reg, ck_n_out_reg;
    wire [7:0] rd_data_h_reg, rd_data_l_reg, dq_out_reg, dq_oe_n_reg, dq_in;
    wire [3:0] cmd_out_reg;
    wire [12:0] addr_out_reg;

    ddr_memory_io_datapath dut_u (.sys_clk, .srst, .wr_valid, .wr_data_h, .wr_data_l, .wr_mask_h, .wr_mask_l,
        .cmd_in, .addr_in, .rd_capture_en, .cap_phase, .rd_ready, .rd_valid_reg, .rd_data_h_reg, .rd_data_l_reg,
        .rd_overrun_reg, .period_start_reg, .dq_in, .dq_out_reg, .dq_oe_n_reg, .dm_out_reg, .dqs_out_reg,
        .dqs_oe_n_reg, .ck_out_reg, .ck_n_out_reg, .cmd_out_reg, .addr_out_reg);
    mem_device_model mem_u (.ck(ck_out_reg), .rd_drive, .word_h, .word_l, .dq(dq_in));

    // ==========
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic sync_period;
        while (period_start_reg !== 1'b1) tick(1);
    endtask
    task automatic check_reset;
        check("reset pins", {ck_out_reg, ck_n_out_reg, dqs_oe_n_reg, dq_oe_n_reg, rd_valid_reg, rd_overrun_reg},
            24'h0ffc);
    endtask
    // one memory period entered in its phase 0 cycle, write and read traffic together
    task automatic do_period(input logic v, input logic en, input logic drv);
        logic [31:0] r;
        seed = lfsr(seed);
        r = seed;
        wr_valid = v;
        {cmd_in, wr_mask_l, wr_mask_h, wr_data_l, wr_data_h} = r[21:0];
        addr_in = r[31:19];
        {word_l, word_h} = r[31:16];
        rd_capture_en = en;
        rd_drive = drv;
        // rise word comes out on the high half of the read pair
        if (drv) exp_q.push_back({word_h, word_l});
        check("period start", {period_start_reg, ck_out_reg}, 2'b10);
        tick(1);
        check("clock pair", {ck_out_reg, ck_n_out_reg}, 2'b10);
        check("command", {cmd_out_reg, addr_out_reg}, {r[21:18], r[31:19]});
        check("strobe", {dqs_out_reg, dqs_oe_n_reg}, {prev_v, ~(v & prev_v)});
        // inputs after phase 0 must be ignored
        wr_valid = ~v;
        wr_data_h = ~r[7:0];
        cmd_in = ~r[21:18];
        tick(2);
        check("high beat", {dqs_oe_n_reg, dq_oe_n_reg, dm_out_reg, dq_out_reg},
            {~(v & prev_v), {8{~v}}, r[16], r[7:0]});
        tick(2);
        check("preamble", {ck_out_reg, dqs_out_reg, dqs_oe_n_reg}, {2'b00, ~v});
        tick(2);
        check("low beat", {dq_oe_n_reg, dm_out_reg, dq_out_reg}, {{8{~v}}, r[17], r[15:8]});
        prev_v = v;
        // prev_v keeps this period's valid for the next strobe check; valid drops until the next period
        wr_valid = 1'b0;
        tick(1);
    endtask
    // capture enable trails the driven words by one period, pairs land a period late
    task automatic burst(input int n);
        for (int i = 0; i <= n; i++) begin
            seed = lfsr(seed);
            do_period(i == 1 || (i > 1 && seed[5]), i > 0, i < n);
        end
        do_period(1'b0, 1'b0, 1'b0);
    endtask
    task automatic drain;
        tick(60);
        check("pairs left", 24'(exp_q.size()), 24'h0);
        sync_period();
    endtask

    // ==========
    // clock, consumer, monitor, watchdog
    initial begin
        sys_clk = 0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        #1;
        rseed = lfsr(rseed);
        rd_ready = !hold_ready && rseed[3];
    end
    always @(posedge sys_clk) begin
        if (srst === 1'b0 && rd_valid_reg === 1'b1 && rd_ready === 1'b1) begin
            if (exp_q.size() == 0) check("extra pair", 24'h1, 24'h0);
            else check("read pair", {rd_data_h_reg, rd_data_l_reg}, exp_q.pop_front());
        end
    end
    initial begin
        #200000;
        bad_count++;
        finish_test;
    end

    // ==========
    // main sequence
    initial begin
        {srst, hold_ready, prev_v, wr_valid, wr_mask_h, wr_mask_l, rd_capture_en, rd_drive} = 8'h80;
        {wr_data_h, wr_data_l, word_h, word_l, cmd_in, addr_in} = '0;
        cap_phase = 3'h6;
        seed = 32'haa76;
        tick(4);
        srst = 0;
        check_reset();
        sync_period();
        burst(9);
        cap_phase = 3'h7;
        do_period(1'b0, 1'b0, 1'b0);
        burst(6);
        drain();
        hold_ready = 1;
        burst(8);
        check("overrun", rd_overrun_reg, 1'b1);
        srst = 1;
        tick(2);
        srst = 0;
        exp_q.delete();
        hold_ready = 0;
        prev_v = 0;
        check_reset();
        sync_period();
        burst(3);
        drain();
        finish_test;
    end
endmodule // ddr_memory_io_datapath_bench
